// file: hdl/stm_pkg.sv
// shared constants and types for the speed-torque mode switch
// assumes one control clock; codes match the user program's setting devices
package stm_pkg;

  // active control mode, encoded as reported in the status word
  typedef enum logic [1:0] {
    STM_POS  = 2'b00,
    STM_SPD  = 2'b01,
    STM_TRQ  = 2'b10,
    STM_CONT = 2'b11
  } stm_mode_e;

  localparam stm_mode_e MODE_RST = STM_POS;

  // mode setting device codes
  localparam logic [15:0] REQ_POS = 16'h0000;
  localparam logic [15:0] REQ_SPD = 16'h000a;
  localparam logic [15:0] REQ_TRQ = 16'h0014;
  localparam logic [15:0] REQ_CONT = 16'h001e;

  // minor error codes
  localparam logic [15:0] ERR_FLAG = 16'h0065;
  localparam logic [15:0] ERR_STOP = 16'h009c;
  localparam logic [15:0] ERR_POL = 16'h009a;
  localparam logic [15:0] ERR_RST = 16'h0000;

  // status word bit positions
  localparam int unsigned ZS_BIT = 3;
  localparam int unsigned MODE_LO = 2;
  localparam int unsigned MODE_HI = 3;

  // setting encodings
  localparam logic [1:0] SPD_SEL_CMD = 2'h0;
  localparam logic [1:0] SPD_SEL_FB = 2'h1;
  localparam logic [1:0] SPD_SEL_AUTO = 2'h2;
  localparam logic TRQ_SEL_CMD = 1'b0;
  localparam logic TRQ_SEL_FB = 1'b1;
  localparam logic ZCHK_ON = 1'b0;
  localparam logic ZCHK_OFF = 1'b1;
  localparam logic POL_VALID = 1'b0;

  // setting-device code to mode; valid flag in bit 2
  function automatic logic [2:0] stm_decode(input logic [15:0] code);
    logic [2:0] r;
    r = 3'h0;
    unique case (code)
      REQ_POS: r = {1'b1, STM_POS};
      REQ_SPD: r = {1'b1, STM_SPD};
      REQ_TRQ: r = {1'b1, STM_TRQ};
      REQ_CONT: r = {1'b1, STM_CONT};
      default: r = 3'h0;
    endcase
    return r;
  endfunction : stm_decode

endpackage : stm_pkg

// file: hdl/stm_sync.sv
// two-flop synchroniser for levels arriving from pins
// assumes each bit is an independent slow level
`timescale 1ns/100ps
`default_nettype none
module stm_sync #(
  parameter int unsigned W = 1
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // levels
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s1_q <= '0;
      s2_q <= '0;
    end else begin
      s1_q <= d_i;
      s2_q <= s1_q;
    end
  end

  assign q_o = s2_q;
endmodule : stm_sync
`default_nettype wire

// file: hdl/stm_init_sel.sv
// initial speed and torque command at a mode switch
// purely combinational; the caller samples it in the switch cycle
`timescale 1ns/100ps
`default_nettype none
module stm_init_sel #(
  parameter int unsigned SPD_W = 32,
  parameter int unsigned TRQ_W = 16
) (
  // switch direction
  input wire stm_pkg::stm_mode_e from_i,
  input wire stm_pkg::stm_mode_e to_i,
  // settings
  input wire logic [1:0] spd_sel_i,
  input wire logic trq_sel_i,
  input wire logic pol_i,
  // present values
  input wire logic [SPD_W-1:0] spd_cur_i,
  input wire logic [SPD_W-1:0] fb_spd_i,
  input wire logic [TRQ_W-1:0] trq_dev_i,
  input wire logic [TRQ_W-1:0] fb_cur_i,
  // results
  output logic [SPD_W-1:0] spd_o,
  output logic [TRQ_W-1:0] trq_o,
  output logic err_pol_o
);
  wire into_trq = (to_i == stm_pkg::STM_TRQ) || (to_i == stm_pkg::STM_CONT);
  wire pol_clash = (trq_sel_i == stm_pkg::TRQ_SEL_FB) && (pol_i == stm_pkg::POL_VALID);
  wire fb_sel = spd_sel_i == stm_pkg::SPD_SEL_FB;
  wire [SPD_W-1:0] mag_fb = fb_spd_i[SPD_W-1] ? SPD_W'(-fb_spd_i) : fb_spd_i;
  wire [SPD_W-1:0] mag_cur = spd_cur_i[SPD_W-1] ? SPD_W'(-spd_cur_i) : spd_cur_i;
  wire [SPD_W-1:0] auto_spd = (mag_fb < mag_cur) ? fb_spd_i : spd_cur_i;
  wire [SPD_W-1:0] cont_spd = fb_sel ? fb_spd_i :
                              (spd_sel_i == stm_pkg::SPD_SEL_AUTO) ? auto_spd : spd_cur_i;
  wire [SPD_W-1:0] pos_spd = fb_sel ? fb_spd_i : '0;

  assign spd_o = (to_i == stm_pkg::STM_CONT) ? cont_spd :
                 (from_i == stm_pkg::STM_POS) ? pos_spd : fb_spd_i;

  assign trq_o = (trq_sel_i == stm_pkg::TRQ_SEL_FB && !pol_clash) ? fb_cur_i : trq_dev_i;
  assign err_pol_o = into_trq && pol_clash;
endmodule : stm_init_sel
`default_nettype wire

// file: hdl/stm_mode_switch.sv
// per-axis control mode switch arbiter for speed-torque control
// assumes settings and data words are stable before a request edge
`timescale 1ns/100ps
`default_nettype none
module stm_mode_switch #(
  parameter int unsigned SPD_W = 32,
  parameter int unsigned TRQ_W = 16,
  parameter int unsigned POS_W = 32
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // switch request and settings
  input wire logic switch_req_i,
  input wire logic [15:0] mode_set_i,
  input wire logic zero_chk_off_i,
  input wire logic [1:0] spd_init_sel_i,
  input wire logic trq_init_sel_i,
  input wire logic torque_polarity_reflect_select_i,
  // servo amplifier feedback
  input wire logic [15:0] servo_state_word_two_i,
  input wire logic [SPD_W-1:0] fb_speed_i,
  input wire logic [TRQ_W-1:0] fb_current_i,
  // axis data
  input wire logic [TRQ_W-1:0] torque_dev_i,
  input wire logic [POS_W-1:0] feed_value_i,
  // positioning engine, same clock; press request is a pin level
  input wire logic pos_busy_i,
  input wire logic pos_launch_done_i,
  input wire logic pos_target_done_i,
  input wire logic pos_vel_ctrl_i,
  input wire logic press_req_i,
  // axis status
  output logic axis_start_accepted_o,
  output logic motion_launch_done_o,
  output logic motion_target_done_o,
  output logic velocity_mode_active_signal_o,
  output logic [15:0] servo_state_word_one_o,
  output logic press_reject_o,
  // minor error report
  output logic err_valid_o,
  output logic [15:0] err_code_o,
  // commands to the amplifier
  output logic cmd_load_o,
  output logic [SPD_W-1:0] speed_cmd_o,
  output logic [TRQ_W-1:0] torque_cmd_o,
  output logic [POS_W-1:0] pos_cmd_o
);
  logic [2:0] sync_w;
  logic req_prev_q;
  stm_pkg::stm_mode_e mode_q;
  stm_pkg::stm_mode_e mode_d;
  logic flag_q;
  logic launch_q;
  logic target_q;
  logic vel_q;
  logic reject_q;
  logic err_v_q;
  logic [15:0] err_c_q;
  logic load_q;
  logic [SPD_W-1:0] spd_q;
  logic [TRQ_W-1:0] trq_q;
  logic [POS_W-1:0] pos_q;
  logic [SPD_W-1:0] spd_init;
  logic [TRQ_W-1:0] trq_init;
  logic err_pol;

  // pin levels cross into the control clock
  stm_sync #(.W(3)) u_sync (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .d_i({press_req_i, servo_state_word_two_i[stm_pkg::ZS_BIT], switch_req_i}),
    .q_o(sync_w)
  );

  wire req_s = sync_w[0];
  wire zero_spd_s = sync_w[1];
  wire press_s = sync_w[2];

  wire req_edge = req_s && !req_prev_q;
  // settings sampled as-is at the edge
  wire [2:0] dec = stm_pkg::stm_decode(mode_set_i);
  wire tgt_valid = dec[2];
  stm_pkg::stm_mode_e tgt;
  assign tgt = stm_pkg::stm_mode_e'(dec[1:0]);

  wire is_pos = mode_q == stm_pkg::STM_POS;
  wire stopped = zero_spd_s || (zero_chk_off_i == stm_pkg::ZCHK_OFF);
  wire same = tgt == mode_q;
  wire pos_leave = is_pos && (tgt == stm_pkg::STM_SPD || tgt == stm_pkg::STM_TRQ);
  wire to_pos = !is_pos && tgt == stm_pkg::STM_POS;
  // continuous entry has no stop check
  wire pos_cont = is_pos && tgt == stm_pkg::STM_CONT;
  wire blocked = (mode_q == stm_pkg::STM_TRQ && tgt == stm_pkg::STM_CONT) ||
                 (mode_q == stm_pkg::STM_CONT && tgt == stm_pkg::STM_TRQ);
  wire flag_err = (pos_leave || pos_cont) && flag_q;
  wire stop_err = ((pos_leave && !flag_q) || to_pos) && !stopped;
  wire err_cond = flag_err || stop_err || blocked;
  wire sw_go = req_edge && tgt_valid && !same && !err_cond;
  wire err_go = req_edge && tgt_valid && err_cond;
  wire [15:0] err_code = stop_err ? stm_pkg::ERR_STOP : stm_pkg::ERR_FLAG;

  assign mode_d = sw_go ? tgt : mode_q;

  stm_init_sel #(.SPD_W(SPD_W), .TRQ_W(TRQ_W)) u_init (
    .from_i(mode_q),
    .to_i(tgt),
    .spd_sel_i(spd_init_sel_i),
    .trq_sel_i(trq_init_sel_i),
    .pol_i(torque_polarity_reflect_select_i),
    .spd_cur_i(spd_q),
    .fb_spd_i(fb_speed_i),
    .trq_dev_i(torque_dev_i),
    .fb_cur_i(fb_current_i),
    .spd_o(spd_init),
    .trq_o(trq_init),
    .err_pol_o(err_pol)
  );

  wire load_spd = sw_go && (tgt == stm_pkg::STM_SPD || tgt == stm_pkg::STM_CONT);
  wire load_trq = sw_go && (tgt == stm_pkg::STM_TRQ || tgt == stm_pkg::STM_CONT);
  wire load_pos = sw_go && tgt == stm_pkg::STM_POS;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      req_prev_q <= 1'b0;
      mode_q <= stm_pkg::MODE_RST;
      flag_q <= 1'b0;
    end else begin
      req_prev_q <= req_s;
      mode_q <= mode_d;
      flag_q <= pos_busy_i || (mode_d != stm_pkg::STM_POS);
    end
  end

  // status outputs; done pulses are masked in the switch cycle
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      launch_q <= 1'b0;
      target_q <= 1'b0;
      vel_q <= 1'b0;
      reject_q <= 1'b0;
    end else begin
      // no done pulse from a switch
      launch_q <= pos_launch_done_i && !sw_go;
      target_q <= pos_target_done_i && !sw_go;
      // velocity signal off in speed mode
      vel_q <= pos_vel_ctrl_i && mode_d == stm_pkg::STM_POS;
      reject_q <= press_s && mode_q == stm_pkg::STM_SPD;
    end
  end

  // error pulse; the code stays until the next error
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      err_v_q <= 1'b0;
      err_c_q <= stm_pkg::ERR_RST;
    end else begin
      err_v_q <= err_go || (load_trq && err_pol);
      if (err_go) begin
        err_c_q <= err_code;
      end else if (load_trq && err_pol) begin
        err_c_q <= stm_pkg::ERR_POL;
      end
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      load_q <= 1'b0;
      spd_q <= '0;
      trq_q <= '0;
      pos_q <= '0;
    end else begin
      load_q <= sw_go;
      if (load_spd) begin
        spd_q <= spd_init;
      end
      if (load_trq) begin
        trq_q <= trq_init;
      end
      if (load_pos) begin
        pos_q <= feed_value_i;
      end
    end
  end

  assign axis_start_accepted_o = flag_q;
  assign motion_launch_done_o = launch_q;
  assign motion_target_done_o = target_q;
  assign velocity_mode_active_signal_o = vel_q;
  assign servo_state_word_one_o = {12'h000, mode_q, 2'b00};
  assign press_reject_o = reject_q;
  assign err_valid_o = err_v_q;
  assign err_code_o = err_c_q;
  assign cmd_load_o = load_q;
  assign speed_cmd_o = spd_q;
  assign torque_cmd_o = trq_q;
  assign pos_cmd_o = pos_q;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  sequence sw_into_spd_s;
    sw_go && is_pos && tgt == stm_pkg::STM_SPD;
  endsequence
  sequence fb_speed_pick_s;
    spd_init_sel_i == stm_pkg::SPD_SEL_FB;
  endsequence

  mode_edge_only_a: assert property (
    mode_q != $past(mode_q) |-> $past(req_edge))
    else $error("mode changed without a request edge");
  switch_taken_a: assert property (
    sw_go && tgt != stm_pkg::STM_POS |=> mode_q == $past(tgt) && axis_start_accepted_o)
    else $error("accepted switch not applied");
  error_keeps_a: assert property (
    err_go |=> mode_q == $past(mode_q) && err_valid_o &&
      (err_code_o == stm_pkg::ERR_FLAG || err_code_o == stm_pkg::ERR_STOP))
    else $error("failed switch changed mode or gave no error");
  leave_pos_a: assert property (
    sw_go && pos_leave |-> !flag_q && stopped)
    else $error("left position mode against condition");
  return_pos_a: assert property (
    sw_go && to_pos |-> stopped)
    else $error("returned to position mode while moving");
  status_mode_a: assert property (
    ##1 servo_state_word_one_o[stm_pkg::MODE_HI:stm_pkg::MODE_LO] == $past(mode_d))
    else $error("status word mode bits wrong");
  no_done_a: assert property (
    sw_go |=> !motion_launch_done_o && !motion_target_done_o)
    else $error("done signal raised by switch");
  flag_hold_a: assert property (
    mode_q != stm_pkg::STM_POS |-> axis_start_accepted_o)
    else $error("start flag dropped outside position mode");
  vel_off_a: assert property (
    mode_q == stm_pkg::STM_SPD [*2] |-> !velocity_mode_active_signal_o)
    else $error("velocity signal on in speed mode");
  press_refuse_a: assert property (
    press_s && mode_q == stm_pkg::STM_SPD |=> press_reject_o)
    else $error("press not refused in speed mode");
  speed_init_a: assert property (
    sw_into_spd_s ##0 fb_speed_pick_s |=> speed_cmd_o == $past(fb_speed_i) && cmd_load_o)
    else $error("initial speed not feedback");
  pos_init_a: assert property (
    load_pos |=> pos_cmd_o == $past(feed_value_i))
    else $error("position command not feed value");
  pol_err_a: assert property (
    load_trq && err_pol |=> err_code_o == stm_pkg::ERR_POL &&
      torque_cmd_o == $past(torque_dev_i))
    else $error("polarity clash not handled");
  swap_free_a: assert property (
    req_edge && ((mode_q == stm_pkg::STM_SPD && tgt == stm_pkg::STM_TRQ) ||
      (mode_q == stm_pkg::STM_TRQ && tgt == stm_pkg::STM_SPD)) |-> sw_go)
    else $error("speed torque swap was blocked");
  zero_chk_skip_a: assert property (
    req_edge && pos_leave && !flag_q && zero_chk_off_i == stm_pkg::ZCHK_OFF |-> sw_go)
    else $error("stop check not skipped");
  cont_entry_a: assert property (
    req_edge && is_pos && tgt == stm_pkg::STM_CONT && !flag_q |-> sw_go)
    else $error("continuous entry waited for stop");
  spd_zero_a: assert property (
    sw_into_spd_s ##0 spd_init_sel_i != stm_pkg::SPD_SEL_FB |=> speed_cmd_o == '0)
    else $error("initial speed not zero");
  trq_init_cmd_a: assert property (
    load_trq && trq_init_sel_i == stm_pkg::TRQ_SEL_CMD |=> torque_cmd_o == $past(torque_dev_i))
    else $error("initial torque not device value");
  trq_init_fb_a: assert property (
    load_trq && trq_init_sel_i == stm_pkg::TRQ_SEL_FB && !err_pol |=> torque_cmd_o == $past(fb_current_i))
    else $error("initial torque not motor current");
  spd_from_trq_a: assert property (
    sw_go && mode_q == stm_pkg::STM_TRQ && tgt == stm_pkg::STM_SPD |=> speed_cmd_o == $past(fb_speed_i))
    else $error("speed after torque not feedback");
endmodule : stm_mode_switch
`default_nettype wire

// file: dv/stm_servo_model.sv
// servo amplifier feedback model for the mode switch bench
// assumes the bench commands motor stop; outputs move on the falling edge
`timescale 1ns/100ps
`default_nettype none
module stm_servo_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // bench command
  input wire logic stop_i,
  // feedback
  output logic [15:0] servo_state_word_two_o,
  output logic [31:0] fb_speed_o,
  output logic [15:0] fb_current_o
);
  logic [15:0] junk_q;

  // unused status bits keep toggling so nothing leans on them
  always_ff @(negedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      junk_q <= 16'h5af0;
    end else begin
      junk_q <= ~junk_q;
    end
  end

  assign servo_state_word_two_o = {junk_q[15:4], stop_i, junk_q[2:0]};
  assign fb_speed_o = stop_i ? 32'h00000000 : 32'h00001234;
  assign fb_current_o = 16'h0321;
endmodule : stm_servo_model
`default_nettype wire

// file: dv/tb_stm_mode_switch.sv
// self-checking bench for the speed-torque mode switch
// assumes the servo model sits on the feedback ports
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin miscompares++; \
  $display("ERROR %0t mismatch %h vs %h", $time, (a), (b)); end end
module tb_stm_mode_switch;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic switch_req_i = 1'b0, zero_chk_off_i = 1'b0, trq_init_sel_i = 1'b0, pol_i = 1'b1;
  logic [15:0] mode_set_i = 16'h0000, torque_dev_i = 16'h0111;
  logic [1:0] spd_init_sel_i = 2'h0;
  logic pos_busy_i = 1'b0, pos_launch_done_i = 1'b0, pos_target_done_i = 1'b0;
  logic pos_vel_ctrl_i = 1'b0, press_req_i = 1'b0, stop = 1'b0;
  logic [15:0] ssw2, ssw1, fb_cur, err_code, trq_cmd;
  logic [31:0] fb_spd, spd_cmd, pos_cmd;
  logic [31:0] feed = 32'h00005a5a;
  logic flag, la_o, ta_o, vel_o, press_o, err_v, load, la, ta;
  int miscompares = 0;
  int samples_checked = 0;

  initial begin
    forever #50 clk_i = ~clk_i;
  end

  stm_servo_model u_servo (.clk_i(clk_i), .nrst_i(nrst_i), .stop_i(stop), .servo_state_word_two_o(ssw2),
    .fb_speed_o(fb_spd), .fb_current_o(fb_cur));

  stm_mode_switch u_dut (.clk_i(clk_i), .nrst_i(nrst_i), .switch_req_i(switch_req_i), .mode_set_i(mode_set_i),
    .zero_chk_off_i(zero_chk_off_i), .spd_init_sel_i(spd_init_sel_i), .trq_init_sel_i(trq_init_sel_i),
    .torque_polarity_reflect_select_i(pol_i), .servo_state_word_two_i(ssw2), .fb_speed_i(fb_spd),
    .fb_current_i(fb_cur), .torque_dev_i(torque_dev_i), .feed_value_i(feed), .pos_busy_i(pos_busy_i),
    .pos_launch_done_i(pos_launch_done_i), .pos_target_done_i(pos_target_done_i),
    .pos_vel_ctrl_i(pos_vel_ctrl_i), .press_req_i(press_req_i), .axis_start_accepted_o(flag),
    .motion_launch_done_o(la_o), .motion_target_done_o(ta_o), .velocity_mode_active_signal_o(vel_o),
    .servo_state_word_one_o(ssw1), .press_reject_o(press_o), .err_valid_o(err_v), .err_code_o(err_code),
    .cmd_load_o(load), .speed_cmd_o(spd_cmd), .torque_cmd_o(trq_cmd), .pos_cmd_o(pos_cmd));

  task automatic report_and_stop;
    if (miscompares == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : report_and_stop

  // one request edge; none marks a request that must be ignored
  task automatic req(input logic [15:0] code, input logic [15:0] err, input stm_pkg::stm_mode_e st,
                     input bit none);
    bit seen;
    bit got_err;
    seen = 1'b0;
    got_err = 1'b0;
    mode_set_i = code;
    switch_req_i = 1'b1;
    for (int i = 0; i < 8 && !seen; i++) begin
      @(negedge clk_i);
      if (load === 1'b1 || err_v === 1'b1) begin
        seen = 1'b1;
        got_err = err_v;
        la = la_o;
        ta = ta_o;
      end
    end
    // a lost answer is counted here; the run still ends in the verdict
    if (!seen && !none) begin
      miscompares++;
      $display("ERROR %0t no answer to request", $time);
    end
    // level drops long enough for a clean next edge
    switch_req_i = 1'b0;
    repeat (3) @(negedge clk_i);
    `CHK(seen, !none)
    `CHK(ssw1, {12'h000, st, 2'h0})
    `CHK(got_err, err != 16'h0000)
    if (err != 16'h0000) `CHK(err_code, err)
  endtask : req

  initial begin
    repeat (5) @(negedge clk_i);
    nrst_i = 1'b1;
    repeat (3) @(negedge clk_i);
    `CHK(ssw1, 16'h0000)
    `CHK(err_code, stm_pkg::ERR_RST)
    `CHK(flag, 1'b0)
    req(stm_pkg::REQ_SPD, stm_pkg::ERR_STOP, stm_pkg::STM_POS, 0);
    pos_busy_i = 1'b1;
    stop = 1'b1;
    req(stm_pkg::REQ_TRQ, stm_pkg::ERR_FLAG, stm_pkg::STM_POS, 0);
    pos_busy_i = 1'b0;
    stop = 1'b0;
    zero_chk_off_i = 1'b1;
    spd_init_sel_i = stm_pkg::SPD_SEL_FB;
    req(stm_pkg::REQ_SPD, 16'h0000, stm_pkg::STM_SPD, 0);
    `CHK(spd_cmd, 32'h00001234)
    `CHK(flag, 1'b1)
    pos_vel_ctrl_i = 1'b1;
    press_req_i = 1'b1;
    repeat (4) @(negedge clk_i);
    `CHK(vel_o, 1'b0)
    `CHK(press_o, 1'b1)
    pos_vel_ctrl_i = 1'b0;
    press_req_i = 1'b0;
    req(stm_pkg::REQ_SPD, 16'h0000, stm_pkg::STM_SPD, 1);
    req(16'h0063, 16'h0000, stm_pkg::STM_SPD, 1);
    zero_chk_off_i = 1'b0;
    // motor stopped before speed to torque
    stop = 1'b1;
    req(stm_pkg::REQ_TRQ, 16'h0000, stm_pkg::STM_TRQ, 0);
    `CHK(trq_cmd, 16'h0111)
    pos_launch_done_i = 1'b1;
    pos_target_done_i = 1'b1;
    req(stm_pkg::REQ_SPD, 16'h0000, stm_pkg::STM_SPD, 0);
    `CHK(la, 1'b0)
    `CHK(ta, 1'b0)
    `CHK(spd_cmd, 32'h00000000)
    pos_launch_done_i = 1'b0;
    pos_target_done_i = 1'b0;
    // control data loaded before the edge
    torque_dev_i = 16'h0222;
    trq_init_sel_i = stm_pkg::TRQ_SEL_FB;
    pol_i = stm_pkg::POL_VALID;
    req(stm_pkg::REQ_TRQ, stm_pkg::ERR_POL, stm_pkg::STM_TRQ, 0);
    `CHK(trq_cmd, 16'h0222)
    // motor running: torque to speed still has no condition
    stop = 1'b0;
    req(stm_pkg::REQ_SPD, 16'h0000, stm_pkg::STM_SPD, 0);
    `CHK(spd_cmd, 32'h00001234)
    pol_i = 1'b1;
    stop = 1'b1;
    req(stm_pkg::REQ_TRQ, 16'h0000, stm_pkg::STM_TRQ, 0);
    `CHK(trq_cmd, 16'h0321)
    stop = 1'b0;
    req(stm_pkg::REQ_POS, stm_pkg::ERR_STOP, stm_pkg::STM_TRQ, 0);
    stop = 1'b1;
    req(stm_pkg::REQ_POS, 16'h0000, stm_pkg::STM_POS, 0);
    `CHK(pos_cmd, 32'h00005a5a)
    `CHK(flag, 1'b0)
    feed = 32'h0000a5a5;
    stop = 1'b0;
    req(stm_pkg::REQ_CONT, 16'h0000, stm_pkg::STM_CONT, 0);
    `CHK(pos_cmd, 32'h00005a5a)
    stop = 1'b1;
    req(stm_pkg::REQ_POS, 16'h0000, stm_pkg::STM_POS, 0);
    `CHK(pos_cmd, 32'h0000a5a5)
    stop = 1'b0;
    zero_chk_off_i = 1'b1;
    spd_init_sel_i = stm_pkg::SPD_SEL_AUTO;
    req(stm_pkg::REQ_SPD, 16'h0000, stm_pkg::STM_SPD, 0);
    `CHK(spd_cmd, 32'h00000000)
    report_and_stop();
  end
endmodule : tb_stm_mode_switch
`default_nettype wire
